//--- slp_pkg.sv
// Shared constants for the serdes lane port: lane counts, word widths, mode codes.
// Assumes a single 200 MHz core clock; all lane and reference clocks are sampled.
package slp_pkg;
  localparam int LANE_W = 64;
  localparam int MAX_LANES = 4;
  localparam int VIRTUAL_LANE_COUNT = 4;
  localparam int LANES_50G = 2;
  localparam int LANES_40G = 4;
  localparam int NARROW_W = 128;
  localparam int WIDE_W = 256;
  localparam int SYNC_DEPTH = 2;
  localparam logic [2:0] GROUP_NARROW = 3'h2;
  localparam logic [2:0] GROUP_WIDE = 3'h4;
  localparam logic [2:0] LANES_50G_CNT = 3'h2;
  localparam logic [2:0] LANES_40G_CNT = 3'h4;
  localparam logic [7:0] ALIGN_WORDS = 8'h10;
  localparam logic [LANE_W-1:0] TX_IDLE_WORD = 64'h0;
  localparam real MCLK_NS = 5.0;
endpackage

//--- slp_stream_if.sv
// Valid/ready word stream between the lane port and its elastic buffer.
// Assumes source and sink share the core clock.
`timescale 1ns/1ps
interface slp_stream_if #(parameter int W = 256);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- slp_skid_buf.sv
// Two-entry elastic buffer: an output register plus one skid entry.
// Assumes one clock; all outputs come from flip-flops.
`timescale 1ns/1ps
module slp_skid_buf #(
  parameter int W = 256
) (
  input wire logic mclk,        // Core clock
  input wire logic rstn,        // Asynchronous reset, active low
  input wire logic srst,        // Synchronous flush
  slp_stream_if.snk in_s,       // Filling side
  slp_stream_if.src out_s       // Draining side
);
  logic out_valid;
  logic [W-1:0] out_data;
  logic skid_valid;
  logic [W-1:0] skid_data;
  logic in_rdy;
  logic take_in;

  assign take_in = in_s.valid && in_rdy;
  assign in_s.ready = in_rdy;
  assign out_s.valid = out_valid;
  assign out_s.data = out_data;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
      in_rdy <= 1'b0;
    end
    else if (srst)
    begin
      out_valid <= 1'b0;
      skid_valid <= 1'b0;
      in_rdy <= 1'b1;
    end
    else
    begin
      if (out_s.ready || !out_valid)
      begin
        if (skid_valid)
        begin
          out_data <= skid_data;
          out_valid <= 1'b1;
          skid_valid <= 1'b0;
          in_rdy <= 1'b1;
        end
        else
        begin
          out_valid <= take_in;
          if (take_in)
            out_data <= in_s.data;
          in_rdy <= 1'b1;
        end
      end
      else if (take_in)
      begin
        // Receiver stalled: park the word, stop taking more
        skid_data <= in_s.data;
        skid_valid <= 1'b1;
        in_rdy <= 1'b0;
      end
    end
  end
endmodule

//--- slp_lane_port.sv
// Lane port of the MAC/PCS toward the serdes macros, with user-side path resets.
// Assumes mclk is the user-side stream clock; lane and reference clocks are sampled.
// Operation
// - Each receive lane word is 64 bits, MSB first received, bit 0 last.
// - Each transmit lane word is 64 bits, MSB first sent, bit 0 last.
// - Each lane word is taken at the rising edge of its own recovered clock.
// - All user-side signals launch and capture on the rising user clock edge.
// - Receive reset is synchronised inside and applied as a synchronous reset.
// - Transmit reset is synchronised inside and applied as a synchronous reset.
// - Four virtual lanes; two physical lanes at 50G, four at 40G.
// - The 128-bit user stream works at both line rates.
// - The 256-bit user stream is allowed only at the 40G rate.
`timescale 1ns/1ps
module slp_lane_port
  import slp_pkg::*;
(
  input wire logic mclk,                                   // Core and user stream clock
  input wire logic rstn,                                   // Asynchronous reset, active low
  input wire logic rx_path_reset,                          // Receive path reset, high
  input wire logic tx_path_reset,                          // Transmit path reset, high
  input wire logic rate_50g,                               // 1: 50G two lanes, 0: 40G four
  input wire logic wide_bus,                               // Request 256-bit user stream
  input wire logic [MAX_LANES-1:0][LANE_W-1:0] rx_lane_data, // Receive lane words
  input wire logic [MAX_LANES-1:0] rx_lane_clk,            // Recovered lane clocks
  input wire logic [MAX_LANES-1:0] rx_lane_reset,          // Lane resets, high
  input wire logic tx_refclk,                              // Transmit reference clock
  input wire logic tx_refclk_reset,                        // Reference clock reset, high
  output logic [MAX_LANES-1:0][LANE_W-1:0] tx_lane_data,   // Transmit lane words
  output logic [WIDE_W-1:0] rx_data,                       // Received user word
  output logic rx_valid,                                   // Received word valid
  input wire logic rx_ready,                               // User accepts received word
  input wire logic [WIDE_W-1:0] tx_data,                   // User word to send
  input wire logic tx_valid,                               // User word valid
  output logic tx_ready,                                   // Port accepts user word
  output logic [MAX_LANES-1:0] rx_lane_aligned,            // Lane alignment reached
  output logic wide_active,                                // 256-bit stream in use
  output logic rate_50g_active                             // Captured line rate
);
  logic [SYNC_DEPTH-1:0] rxr_sync;
  logic [SYNC_DEPTH-1:0] txr_sync;
  logic [SYNC_DEPTH-1:0] rate_sync;
  logic [SYNC_DEPTH-1:0] wide_sync;
  logic rx_rst;
  logic tx_rst;
  logic [2:0] active_lanes;
  logic [2:0] group_size;
  logic [MAX_LANES-1:0] pend;
  logic [MAX_LANES-1:0] take;
  logic [MAX_LANES-1:0][LANE_W-1:0] lane_word;
  logic [MAX_LANES-1:0][LANE_W-1:0] asm_word;
  logic [2:0] asm_cnt;
  logic [1:0] rd_ptr;
  logic asm_full;
  logic [WIDE_W-1:0] asm_packed;
  logic [SYNC_DEPTH-1:0] refc_sync;
  logic refc_d;
  logic [SYNC_DEPTH-1:0] refr_sync;
  logic ref_edge;
  logic tx_half;
  logic [WIDE_W-1:0] tx_hold;
  logic tx_hold_valid;
  logic tx_take;

  slp_stream_if #(.W(WIDE_W)) rx_in ();
  slp_stream_if #(.W(WIDE_W)) rx_out ();

  // Path resets and mode pins pass two flops first
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxr_sync <= '1;
      txr_sync <= '1;
      rate_sync <= '0;
      wide_sync <= '0;
    end
    else
    begin
      rxr_sync <= {rxr_sync[0], rx_path_reset};
      txr_sync <= {txr_sync[0], tx_path_reset};
      rate_sync <= {rate_sync[0], rate_50g};
      wide_sync <= {wide_sync[0], wide_bus};
    end
  end

  assign rx_rst = rxr_sync[SYNC_DEPTH-1];
  assign tx_rst = txr_sync[SYNC_DEPTH-1];

  // Mode is taken only while both paths are held in reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rate_50g_active <= 1'b0;
      wide_active <= 1'b0;
    end
    else if (rx_rst && tx_rst)
    begin
      rate_50g_active <= rate_sync[SYNC_DEPTH-1];
      wide_active <= wide_sync[SYNC_DEPTH-1] && !rate_sync[SYNC_DEPTH-1];
    end
  end

  assign active_lanes = rate_50g_active ? LANES_50G_CNT : LANES_40G_CNT;
  assign group_size = wide_active ? GROUP_WIDE : GROUP_NARROW;

  // Per-lane capture on the sampled recovered clock
  genvar l;
  generate
    for (l = 0; l < MAX_LANES; l++)
    begin : g_lane
      logic [SYNC_DEPTH-1:0] clk_sync;
      logic clk_d;
      logic [SYNC_DEPTH-1:0] rst_sync;
      logic [LANE_W-1:0] dat_s1;
      logic [LANE_W-1:0] dat_s2;
      logic [LANE_W-1:0] dat_s3;
      logic [7:0] align_cnt;
      logic edge_seen;
      logic lane_rst;

      assign edge_seen = clk_sync[SYNC_DEPTH-1] && !clk_d;
      assign lane_rst = rst_sync[SYNC_DEPTH-1] || rx_rst || (l >= active_lanes);

      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          clk_sync <= '0;
          clk_d <= 1'b0;
          rst_sync <= '1;
          dat_s1 <= '0;
          dat_s2 <= '0;
          dat_s3 <= '0;
        end
        else
        begin
          clk_sync <= {clk_sync[0], rx_lane_clk[l]};
          clk_d <= clk_sync[SYNC_DEPTH-1];
          rst_sync <= {rst_sync[0], rx_lane_reset[l]};
          dat_s1 <= rx_lane_data[l];
          dat_s2 <= dat_s1;
          dat_s3 <= dat_s2;
        end
      end

      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          align_cnt <= '0;
          rx_lane_aligned[l] <= 1'b0;
          pend[l] <= 1'b0;
          lane_word[l] <= '0;
        end
        else if (lane_rst)
        begin
          align_cnt <= '0;
          rx_lane_aligned[l] <= 1'b0;
          pend[l] <= 1'b0;
        end
        else if (edge_seen)
        begin
          // Older sample is the level just before the rising edge
          lane_word[l] <= dat_s3;
          if (align_cnt != ALIGN_WORDS)
            align_cnt <= align_cnt + 8'h01;
          else
            rx_lane_aligned[l] <= 1'b1;
          // A new word wins over a take in the same cycle
          pend[l] <= rx_lane_aligned[l] || (pend[l] && !take[l]);
        end
        else if (take[l])
          pend[l] <= 1'b0;
      end

      assign take[l] = pend[l] && !asm_full && (rd_ptr == 2'(l));
    end
  endgenerate

  assign asm_full = (asm_cnt == group_size);

  // Gather lane words in lane order, earliest lane in the high bits
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      asm_cnt <= '0;
      rd_ptr <= '0;
      asm_word <= '0;
    end
    else if (rx_rst)
    begin
      asm_cnt <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (|take)
      begin
        asm_word[asm_cnt[1:0]] <= lane_word[rd_ptr];
        asm_cnt <= asm_cnt + 3'h1;
        rd_ptr <= ({1'b0, rd_ptr} + 3'h1 == active_lanes) ? 2'h0 : rd_ptr + 2'h1;
      end
      else if (rx_in.valid && rx_in.ready)
        asm_cnt <= '0;
    end
  end

  always_comb
  begin
    if (wide_active)
      asm_packed = {asm_word[0], asm_word[1], asm_word[2], asm_word[3]};
    else
      asm_packed = {{(WIDE_W-NARROW_W){1'b0}}, asm_word[0], asm_word[1]};
  end

  assign rx_in.valid = asm_full;
  assign rx_in.data = asm_packed;
  assign rx_out.ready = rx_ready;
  assign rx_data = rx_out.data;
  assign rx_valid = rx_out.valid;

  slp_skid_buf #(.W(WIDE_W)) u_rx_buf (
    .mclk(mclk),
    .rstn(rstn),
    .srst(rx_rst),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  // Transmit reference clock and its reset are sampled
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      refc_sync <= '0;
      refc_d <= 1'b0;
      refr_sync <= '1;
    end
    else
    begin
      refc_sync <= {refc_sync[0], tx_refclk};
      refc_d <= refc_sync[SYNC_DEPTH-1];
      refr_sync <= {refr_sync[0], tx_refclk_reset};
    end
  end

  assign ref_edge = refc_sync[SYNC_DEPTH-1] && !refc_d;
  assign tx_take = tx_valid && tx_ready;

  // User word staging, one word deep
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_hold <= '0;
      tx_hold_valid <= 1'b0;
      tx_ready <= 1'b0;
    end
    else if (tx_rst)
    begin
      tx_hold_valid <= 1'b0;
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_take)
      begin
        tx_hold <= tx_data;
        tx_hold_valid <= 1'b1;
        tx_ready <= 1'b0;
      end
      else if (ref_edge && !refr_sync[SYNC_DEPTH-1])
      begin
        tx_hold_valid <= 1'b0;
        tx_ready <= 1'b1;
      end
      else
        tx_ready <= !tx_hold_valid;
    end
  end

  // Spread the staged word over the lanes, earliest bits in each MSB
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_lane_data <= '0;
      tx_half <= 1'b0;
    end
    else if (tx_rst || refr_sync[SYNC_DEPTH-1])
    begin
      tx_lane_data <= '0;
      tx_half <= 1'b0;
    end
    else if (ref_edge)
    begin
      if (!tx_hold_valid)
        tx_lane_data <= {MAX_LANES{TX_IDLE_WORD}};
      else if (wide_active)
      begin
        for (int i = 0; i < MAX_LANES; i++)
          tx_lane_data[i] <= tx_hold[WIDE_W-1-i*LANE_W -: LANE_W];
      end
      else
      begin
        tx_lane_data[{tx_half, 1'b0}] <= tx_hold[NARROW_W-1 -: LANE_W];
        tx_lane_data[{tx_half, 1'b1}] <= tx_hold[LANE_W-1:0];
        if (!rate_50g_active)
          tx_half <= !tx_half;
      end
    end
  end
endmodule

//--- slp_lane_port_sva.sv
// Concurrent checks on the lane port's top-level ports.
// Assumes every port is sampled on the rising edge of mclk.
`timescale 1ns/1ps
module slp_lane_port_sva
  import slp_pkg::*;
(
  input wire logic mclk, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic rx_path_reset, // Receive path reset
  input wire logic tx_path_reset, // Transmit path reset
  input wire logic rate_50g, // Rate pin
  input wire logic wide_bus, // Wide request pin
  input wire logic [MAX_LANES-1:0] rx_lane_reset, // Lane resets
  input wire logic tx_refclk, // Reference clock
  input wire logic tx_refclk_reset, // Reference clock reset
  input wire logic [MAX_LANES-1:0][LANE_W-1:0] tx_lane_data, // Lane words out
  input wire logic [WIDE_W-1:0] rx_data, // Received word
  input wire logic rx_valid, // Received valid
  input wire logic rx_ready, // User ready
  input wire logic tx_valid, // User valid
  input wire logic tx_ready, // Port ready
  input wire logic [MAX_LANES-1:0] rx_lane_aligned, // Alignment flags
  input wire logic wide_active, // Wide mode
  input wire logic rate_50g_active // Captured rate
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic ref_q;
  logic [3:0] since;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) ref_q <= 1'b0;
    else ref_q <= tx_refclk;
  // Cycles since the reference clock was last seen rising
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) since <= 4'hf;
    else if (tx_refclk && !ref_q) since <= 4'h0;
    else if (since != 4'hf) since <= since + 4'h1;
  sequence s_both_rst;
    (rx_path_reset && tx_path_reset) [*5];
  endsequence
  sequence s_tx_take;
    tx_valid && tx_ready;
  endsequence
  a_rst_quiet: assert property (disable iff (1'b0) !rstn |->
    !rx_valid && !tx_ready && tx_lane_data == '0) else $error("outputs live in reset");
  a_rx_hold_word: assert property (disable iff (!rstn || rx_path_reset)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx word lost");
  a_tx_rst_idle: assert property (tx_path_reset [*4] |->
    tx_lane_data == '0 && !tx_ready) else $error("tx active in reset");
  a_rx_rst_flush: assert property (rx_path_reset [*4] |-> !rx_valid)
    else $error("rx active in reset");
  a_tx_take_drop: assert property (s_tx_take |=> !tx_ready) else $error("ready held");
  a_tx_ref_paced: assert property (disable iff (!rstn || tx_path_reset || tx_refclk_reset)
    !$stable(tx_lane_data) |-> since inside {[1:6]}) else $error("tx word off refclk");
  a_narrow_upper: assert property (rx_valid && !wide_active |-> rx_data[255:128] == '0)
    else $error("narrow upper bits set");
  a_wide_40g: assert property (wide_active |-> !rate_50g_active) else $error("wide at 50g");
  a_lane_count: assert property (rate_50g_active |-> rx_lane_aligned[3:2] == 2'h0)
    else $error("inactive lane aligned");
  a_lane_rst_clr: assert property (rx_lane_reset[0] [*4] |-> !rx_lane_aligned[0])
    else $error("lane aligned in reset");
  a_mode_capture: assert property (s_both_rst |-> rate_50g_active == rate_50g &&
    wide_active == (wide_bus && !rate_50g)) else $error("mode not captured");
endmodule
bind slp_lane_port slp_lane_port_sva u_sva (.mclk(mclk), .rstn(rstn),
  .rx_path_reset(rx_path_reset), .tx_path_reset(tx_path_reset), .rate_50g(rate_50g),
  .wide_bus(wide_bus), .rx_lane_reset(rx_lane_reset), .tx_refclk(tx_refclk),
  .tx_refclk_reset(tx_refclk_reset), .tx_lane_data(tx_lane_data), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_lane_aligned(rx_lane_aligned), .wide_active(wide_active),
  .rate_50g_active(rate_50g_active));

//--- slp_serdes_model.sv
// Behavioural serdes macros: recovered lane clocks, lane words, reference clock.
// Assumes a 160 ns lane and reference clock period.
`timescale 1ns/1ps
module slp_serdes_model
  import slp_pkg::*;
(
  output logic [MAX_LANES-1:0][LANE_W-1:0] rx_lane_data, // Lane words
  output logic [MAX_LANES-1:0] rx_lane_clk, // Recovered clocks
  output logic [MAX_LANES-1:0] rx_lane_reset, // Lane resets
  output logic tx_refclk, // Reference clock
  output logic tx_refclk_reset // Reference clock reset
);
  int n;
  initial
  begin
    n = 0;
    rx_lane_clk = '0;
    rx_lane_reset = '1;
    rx_lane_data = '0;
    tx_refclk = 1'b0;
    tx_refclk_reset = 1'b1;
    forever
    begin
      #80;
      rx_lane_clk = '1;
      tx_refclk = 1'b1;
      #80;
      rx_lane_clk = '0;
      tx_refclk = 1'b0;
      n++;
      // Words change on the falling edge, steady at the rising one
      for (int l = 0; l < MAX_LANES; l++)
        rx_lane_data[l] = {8'(l + 1), 24'h0, 32'(n)};
      // Clocks are on frequency from the fourth cycle
      if (n == 4)
      begin
        rx_lane_reset = '0;
        tx_refclk_reset = 1'b0;
      end
    end
  end
endmodule

//--- slp_tb.sv
// Self-checking bench for slp_lane_port in 50G narrow, 40G wide and 40G narrow modes.
// Assumes the serdes model drives all lane-side inputs.
`timescale 1ns/1ps
module tb
  import slp_pkg::*;
;
  logic mclk, rstn, rx_path_reset, tx_path_reset, rate_50g, wide_bus, rx_ready, tx_valid;
  logic [MAX_LANES-1:0][LANE_W-1:0] rx_lane_data, tx_lane_data;
  logic [MAX_LANES-1:0] rx_lane_clk, rx_lane_reset, rx_lane_aligned;
  logic tx_refclk, tx_refclk_reset, rx_valid, tx_ready, wide_active, rate_50g_active;
  logic [WIDE_W-1:0] rx_data, tx_data;
  logic [31:0] seed = 32'h41f3;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  slp_serdes_model u_model (.rx_lane_data(rx_lane_data), .rx_lane_clk(rx_lane_clk),
    .rx_lane_reset(rx_lane_reset), .tx_refclk(tx_refclk), .tx_refclk_reset(tx_refclk_reset));
  slp_lane_port DUT (.mclk(mclk), .rstn(rstn), .rx_path_reset(rx_path_reset),
    .tx_path_reset(tx_path_reset), .rate_50g(rate_50g), .wide_bus(wide_bus),
    .rx_lane_data(rx_lane_data), .rx_lane_clk(rx_lane_clk), .rx_lane_reset(rx_lane_reset),
    .tx_refclk(tx_refclk), .tx_refclk_reset(tx_refclk_reset), .tx_lane_data(tx_lane_data),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_lane_aligned(rx_lane_aligned),
    .wide_active(wide_active), .rate_50g_active(rate_50g_active));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string what, logic [WIDE_W-1:0] seen, logic [WIDE_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run_mode(logic r50, logic wide);
    int lanes, per, half, got, prev;
    logic [WIDE_W-1:0] exp, d, hold;
    lanes = r50 ? 2 : 4;
    per = (wide && !r50) ? 4 : 2;
    half = 0;
    rx_path_reset = 1'b1;
    tx_path_reset = 1'b1;
    rate_50g = r50;
    wide_bus = wide;
    repeat (8) @(negedge mclk);
    check("rate", rate_50g_active, r50);
    check("wide", wide_active, wide & ~r50);
    rx_path_reset = 1'b0;
    tx_path_reset = 1'b0;
    got = 0;
    while (got < 7)
    begin
      @(negedge mclk);
      seed = lfsr(seed);
      rx_ready = (got != 2) && (seed[1:0] != 2'h0);
      if (got == 2)
      begin
        // Stall shorter than a lane overrun, so the buffer holds and no word is lost
        while (rx_valid !== 1'b1) @(negedge mclk);
        hold = rx_data;
        repeat (40) @(negedge mclk);
        check("hold", rx_valid, 1'b1);
        check("hold_data", rx_data, hold);
        rx_ready = 1'b1;
      end
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
      begin
        exp = '0;
        for (int k = 0; k < per; k++)
          exp[(per - 1 - k) * 64 +: 64] = {8'(half + k + 1), 24'h0, rx_data[31:0]};
        check("rx_data", rx_data, exp);
        if (got > 0)
          check("rx_seq", rx_data[31:0], 32'(half == 0 ? prev + 1 : prev));
        check("aligned", rx_lane_aligned, r50 ? 4'h3 : 4'hf);
        prev = rx_data[31:0];
        half = (half + per < lanes) ? half + per : 0;
        got++;
      end
    end
    half = 0;
    repeat (3)
    begin
      for (int i = 0; i < 8; i++)
      begin
        seed = lfsr(seed);
        d[i * 32 +: 32] = seed;
      end
      if (per == 2)
        d[255:128] = '0;
      tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      tx_valid = 1'b0;
      check("tx_ready", tx_ready, 1'b0);
      while (tx_ready !== 1'b1) @(negedge mclk);
      for (int k = 0; k < per; k++)
        check("tx_lane", tx_lane_data[half + k], d[(per - 1 - k) * 64 +: 64]);
      half = (half + per < lanes) ? half + per : 0;
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    rstn = 1'b0;
    rx_path_reset = 1'b1;
    tx_path_reset = 1'b1;
    rate_50g = 1'b1;
    wide_bus = 1'b1;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = '0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    run_mode(1'b1, 1'b1);
    run_mode(1'b0, 1'b1);
    run_mode(1'b0, 1'b0);
    close_out();
  end
endmodule
